// ---- src/flash_cmd_consts.vh ----
`ifndef FLASH_CMD_CONSTS_VH
`define FLASH_CMD_CONSTS_VH

// ****************************************************************
// opcodes
// ****************************************************************
`define OP_JEDEC_ID         8'h9f
`define OP_READ_PARAM_AREA  8'h5a
`define OP_SEC_ERASE        8'h44
`define OP_SEC_PROGRAM      8'h42
`define OP_SEC_READ         8'h48
`define OP_SET_READ_PARAMS  8'hc0
`define OP_SET_BURST_WRAP   8'h77
`define OP_ENTER_FOUR_WIRE  8'h38
`define OP_EXIT_FOUR_WIRE   8'hff
`define OP_WRITE_ENABLE     8'h06
`define OP_WRITE_DISABLE    8'h04
`define OP_READ_STATUS      8'h05
`define OP_RESET_ENABLE     8'h66
`define OP_RESET_DEVICE     8'h99

// ****************************************************************
// frame bit counts
// ****************************************************************
`define BITS_ZERO           6'h00
`define BITS_OPCODE         6'h08
`define BITS_PARAM          6'h10
`define BITS_ADDR           6'h20
`define BITS_DATA           6'h28
`define STEP_SERIAL         6'h01
`define STEP_QUAD           6'h04
`define OBIT_SERIAL         3'h1
`define OBIT_QUAD           3'h4
`define OBIT_ZERO           3'h0

// ****************************************************************
// security register address decode and storage
// ****************************************************************
`define SEC_HI_ZERO         8'h00
`define SEC_MID_ZERO        4'h0
`define SEC_SEL_1           4'h1
`define SEC_SEL_2           4'h2
`define SEC_SEL_3           4'h3
`define SEC_NONE            2'h0
`define SEC_ONE             2'h1
`define SEC_TWO             2'h2
`define SEC_THREE           2'h3
`define SEC_DEPTH           768
`define SEC_BYTES           256
`define ERASED_BYTE         8'hff

// ****************************************************************
// status, defaults and timing
// ****************************************************************
`define STAT_BUSY           0
`define STAT_WEN            1
`define RPARAM_RESET        8'h00
`define SWRAP_RESET         2'h0
`define SPI_FAST_DUMMY      4'h8
`define DUMMY_MIN           4'h2
`define WRAP_MIN            7'h08
`define ID_LAST             2'h2
`define CLK_MHZ             40
`define ERASE_TIME_US       1000
`define ERASE_ONE           24'h000001
`define ERASE_IDLE          24'h000000

// ****************************************************************
// pin sync vector positions and parameter area signature
// ****************************************************************
`define PIN_CS              0
`define PIN_SCLK            1
`define PIN_IO0             2
`define PIN_IO3             5
`define SYNC_IDLE           6'h01
`define SFDP_SIG0           8'h53
`define SFDP_SIG1           8'h46
`define SFDP_SIG2           8'h44
`define SFDP_SIG3           8'h50
`define SFDP_BLANK          8'hff

`endif

// ---- src/flash_id_security_param_cmds.v ----
`timescale 1ns/1ps
`include "flash_cmd_consts.vh"

module flash_id_security_param_cmds #(
  parameter [7:0] manufacturer_id = 8'h5c,  // arbitrary value
  parameter [7:0] memory_type     = 8'h3a,  // arbitrary value
  parameter [7:0] capacity_code   = 8'h16,  // arbitrary value
  parameter       erase_time_us   = `ERASE_TIME_US
) (
  input  wire       clk,
  input  wire       rst,
  input  wire       cs_n,
  input  wire       sclk,
  input  wire       serial_in,
  input  wire [2:0] quad_in,
  output wire [3:0] io_out,
  output wire [3:0] io_oe,
  input  wire       quad_enable_bit,
  input  wire [2:0] security_lock_bits,
  output wire       busy,
  output wire       write_enable_latch,
  output wire       four_wire_command_mode,
  output wire [7:0] read_parameter_byte,
  output wire [1:0] serial_wrap_bits,
  output wire [3:0] fast_read_dummy_clocks,
  output wire [6:0] wrap_length
);

  localparam [31:0] erase_total = erase_time_us * `CLK_MHZ;  // cut to the counter width where it loads

  // ****************************************************************
  // helpers
  // ****************************************************************
  // which security register an address selects, zero for none
  function [1:0] sec_select;
    input [23:0] addr;
    begin
      sec_select = `SEC_NONE;
      if (addr[23:16] == `SEC_HI_ZERO && addr[11:8] == `SEC_MID_ZERO)
      begin
        case (addr[15:12])
          `SEC_SEL_1: sec_select = `SEC_ONE;
          `SEC_SEL_2: sec_select = `SEC_TWO;
          `SEC_SEL_3: sec_select = `SEC_THREE;
          default:    sec_select = `SEC_NONE;
        endcase
      end
    end
  endfunction

  function [9:0] mem_index;
    input [1:0] sec;
    input [7:0] byte_addr;
    begin
      mem_index = {sec - `SEC_ONE, byte_addr};
    end
  endfunction

  // minimal table: signature then blank
  function [7:0] sfdp_byte;
    input [7:0] a;
    begin
      case (a)
        8'h00:   sfdp_byte = `SFDP_SIG0;
        8'h01:   sfdp_byte = `SFDP_SIG1;
        8'h02:   sfdp_byte = `SFDP_SIG2;
        8'h03:   sfdp_byte = `SFDP_SIG3;
        default: sfdp_byte = `SFDP_BLANK;
      endcase
    end
  endfunction

  // ****************************************************************
  // pin synchronisers and glitch filter
  // ****************************************************************
  reg  [5:0] sync1_ff;
  reg  [5:0] sync2_ff;
  reg  [5:0] sync3_ff;
  reg  [5:0] filt_ff;
  reg  [5:0] prev_ff;
  wire [5:0] agree = ~(sync2_ff ^ sync3_ff);

  // a pin level only counts once the second and third stages agree
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_ff <= `SYNC_IDLE;
      sync2_ff <= `SYNC_IDLE;
      sync3_ff <= `SYNC_IDLE;
      filt_ff  <= `SYNC_IDLE;
      prev_ff  <= `SYNC_IDLE;
    end
    else
    begin
      sync1_ff <= {quad_in, serial_in, sclk, cs_n};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      filt_ff  <= (sync3_ff & agree) | (filt_ff & ~agree);
      prev_ff  <= filt_ff;
    end
  end

  wire cs_low    = ~filt_ff[`PIN_CS];
  wire cs_rise   = filt_ff[`PIN_CS] & ~prev_ff[`PIN_CS];
  wire sclk_rise = filt_ff[`PIN_SCLK] & ~prev_ff[`PIN_SCLK];
  wire sclk_fall = ~filt_ff[`PIN_SCLK] & prev_ff[`PIN_SCLK];

  // ****************************************************************
  // state
  // ****************************************************************
  reg [31:0] shift_ff;
  reg [5:0]  bitcnt_ff;
  reg [7:0]  opcode_ff;
  reg [23:0] addr_ff;
  reg [7:0]  ptr_ff;
  reg        cmd_busy_ff;
  reg [7:0]  out_shift_ff;
  reg [2:0]  obit_ff;
  reg        tx_en_ff;
  reg [1:0]  id_idx_ff;
  reg        prog_any_ff;
  reg        wen_ff;
  reg        busy_ff;
  reg        quad_ff;
  reg        rst_en_ff;
  reg [7:0]  rparam_ff;
  reg [1:0]  swrap_ff;
  reg [23:0] erase_cnt_ff;
  reg [1:0]  erase_sec_ff;
  reg [7:0]  sec_mem [0:`SEC_DEPTH-1];
  integer    i;

  wire [5:0]  step      = quad_ff ? `STEP_QUAD : `STEP_SERIAL;
  wire [2:0]  ostep     = quad_ff ? `OBIT_QUAD : `OBIT_SERIAL;
  wire [3:0]  nib       = filt_ff[`PIN_IO3:`PIN_IO0];
  wire [31:0] nxt_shift = quad_ff ? {shift_ff[27:0], nib} : {shift_ff[30:0], nib[0]};
  wire [5:0]  nxt_bits  = bitcnt_ff + step;
  wire [1:0]  sec_cur   = sec_select(addr_ff);
  // the lock index is only meaningful once a register is selected
  wire        sec_ok    = (sec_cur != `SEC_NONE) && !security_lock_bits[sec_cur - `SEC_ONE];

  // decode of read commands and where their data starts
  wire rd_id     = (opcode_ff == `OP_JEDEC_ID) && !cmd_busy_ff;
  wire rd_status = (opcode_ff == `OP_READ_STATUS);
  wire rd_param  = (opcode_ff == `OP_READ_PARAM_AREA) && !quad_ff && !cmd_busy_ff;
  wire rd_sec    = (opcode_ff == `OP_SEC_READ) && !quad_ff && !cmd_busy_ff
                   && (sec_cur != `SEC_NONE);
  wire long_rd   = rd_param | rd_sec;
  wire tx_ok     = cs_low && bitcnt_ff >= (long_rd ? `BITS_DATA : `BITS_OPCODE)
                   && (rd_id | rd_status | long_rd);

  // program strobe fires on each completed data byte of an enabled, unlocked, serial-mode program when not busy
  wire prog_phase = (opcode_ff == `OP_SEC_PROGRAM) && bitcnt_ff >= `BITS_ADDR;
  wire prog_fire  = sclk_rise && cs_low && prog_phase && nxt_bits == `BITS_DATA
                    && wen_ff && !quad_ff && !cmd_busy_ff && sec_ok;
  wire erase_done = busy_ff && erase_cnt_ff == `ERASE_ONE;

  // ****************************************************************
  // command frame, output shifter and device state
  // ****************************************************************
  // one process owns all control flags so that set and clear ordering is explicit
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      shift_ff     <= 32'h00000000;
      bitcnt_ff    <= `BITS_ZERO;
      opcode_ff    <= 8'h00;
      addr_ff      <= 24'h000000;
      ptr_ff       <= 8'h00;
      cmd_busy_ff  <= 1'b0;
      out_shift_ff <= 8'h00;
      obit_ff      <= `OBIT_ZERO;
      tx_en_ff     <= 1'b0;
      id_idx_ff    <= 2'h0;
      prog_any_ff  <= 1'b0;
      wen_ff       <= 1'b0;
      busy_ff      <= 1'b0;
      quad_ff      <= 1'b0;
      rst_en_ff    <= 1'b0;
      rparam_ff    <= `RPARAM_RESET;
      swrap_ff     <= `SWRAP_RESET;
      erase_cnt_ff <= `ERASE_IDLE;
      erase_sec_ff <= `SEC_NONE;
    end
    else
    begin
      // self-timed erase countdown
      if (busy_ff)
        erase_cnt_ff <= erase_cnt_ff - `ERASE_ONE;
      if (erase_done)
      begin
        busy_ff <= 1'b0;
        wen_ff  <= 1'b0;
      end

      if (!cs_low)
      begin
        bitcnt_ff   <= `BITS_ZERO;
        obit_ff     <= `OBIT_ZERO;
        tx_en_ff    <= 1'b0;
        id_idx_ff   <= 2'h0;
        prog_any_ff <= 1'b0;
      end
      else
      begin
        // input bits are taken on rising link clock edges
        if (sclk_rise)
        begin
          shift_ff <= nxt_shift;
          if (prog_phase && nxt_bits == `BITS_DATA)
            bitcnt_ff <= `BITS_ADDR;            // recycle the byte counter per data byte
          else if (bitcnt_ff < `BITS_DATA)
            bitcnt_ff <= nxt_bits;
          if (bitcnt_ff < `BITS_OPCODE && nxt_bits == `BITS_OPCODE)
          begin
            opcode_ff   <= nxt_shift[7:0];
            cmd_busy_ff <= busy_ff;
          end
          if (bitcnt_ff < `BITS_ADDR && nxt_bits == `BITS_ADDR)
          begin
            addr_ff <= nxt_shift[23:0];
            ptr_ff  <= nxt_shift[7:0];
          end
          if (prog_fire)
          begin
            ptr_ff      <= ptr_ff + 8'h01;      // stays inside the register
            prog_any_ff <= 1'b1;
          end
        end
        // output bits change on falling link clock edges
        if (sclk_fall && tx_ok)
        begin
          tx_en_ff <= 1'b1;
          obit_ff  <= obit_ff + ostep;
          if (obit_ff == `OBIT_ZERO)
          begin
            if (rd_id)
            begin
              case (id_idx_ff)
                2'h0:    out_shift_ff <= manufacturer_id;
                2'h1:    out_shift_ff <= memory_type;
                default: out_shift_ff <= capacity_code;
              endcase
              id_idx_ff <= (id_idx_ff == `ID_LAST) ? 2'h0 : id_idx_ff + 2'h1;
            end
            else if (rd_status)
              out_shift_ff <= {6'h00, wen_ff, busy_ff};
            else if (rd_param)
            begin
              out_shift_ff <= sfdp_byte(ptr_ff);
              ptr_ff       <= ptr_ff + 8'h01;
            end
            else
            begin
              out_shift_ff <= sec_mem[mem_index(sec_cur, ptr_ff)];
              ptr_ff       <= ptr_ff + 8'h01;
            end
          end
          else
            out_shift_ff <= quad_ff ? {out_shift_ff[3:0], 4'h0} : {out_shift_ff[6:0], 1'b0};
        end
      end

      // commands that act when select rises
      if (cs_rise)
      begin
        rst_en_ff <= (opcode_ff == `OP_RESET_ENABLE) && bitcnt_ff == `BITS_OPCODE;
        if (!busy_ff)
        begin
          if (opcode_ff == `OP_WRITE_DISABLE && bitcnt_ff == `BITS_OPCODE)
            wen_ff <= 1'b0;
          if (opcode_ff == `OP_SEC_PROGRAM && prog_any_ff)
            wen_ff <= 1'b0;
          if (opcode_ff == `OP_WRITE_ENABLE && bitcnt_ff == `BITS_OPCODE)
            wen_ff <= 1'b1;
          if (opcode_ff == `OP_ENTER_FOUR_WIRE && bitcnt_ff == `BITS_OPCODE && !quad_ff
              && quad_enable_bit)
          begin
            quad_ff        <= 1'b1;
            rparam_ff[1:0] <= swrap_ff;
          end
          if (opcode_ff == `OP_EXIT_FOUR_WIRE && bitcnt_ff == `BITS_OPCODE && quad_ff)
          begin
            quad_ff  <= 1'b0;
            swrap_ff <= rparam_ff[1:0];
          end
          if (opcode_ff == `OP_SET_READ_PARAMS && bitcnt_ff == `BITS_PARAM && quad_ff)
            rparam_ff <= shift_ff[7:0];
          if (opcode_ff == `OP_SET_BURST_WRAP && bitcnt_ff == `BITS_DATA && !quad_ff)  // wrap byte after 3 dummies
            swrap_ff <= shift_ff[5:4];
          if (opcode_ff == `OP_SEC_ERASE && bitcnt_ff == `BITS_ADDR
              && !quad_ff && wen_ff && sec_ok)
          begin
            busy_ff      <= 1'b1;
            erase_cnt_ff <= erase_total[23:0];
            erase_sec_ff <= sec_cur;
          end
        end
        // accepted reset aborts the erase and restores defaults
        if (opcode_ff == `OP_RESET_DEVICE && bitcnt_ff == `BITS_OPCODE && rst_en_ff)
        begin
          busy_ff      <= 1'b0;
          erase_cnt_ff <= `ERASE_IDLE;
          wen_ff       <= 1'b0;
          quad_ff      <= 1'b0;
          rparam_ff    <= `RPARAM_RESET;
          swrap_ff     <= `SWRAP_RESET;
        end
      end
    end
  end

  // ****************************************************************
  // security register storage
  // ****************************************************************
  // erasable storage keeps its content across reset, so it has no reset term
  always @(posedge clk)
  begin
    if (prog_fire)
      sec_mem[mem_index(sec_cur, ptr_ff)] <= sec_mem[mem_index(sec_cur, ptr_ff)] & nxt_shift[7:0];
    if (erase_done)
      for (i = 0; i < `SEC_BYTES; i = i + 1)
        sec_mem[mem_index(erase_sec_ff, i[7:0])] <= `ERASED_BYTE;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // serial mode drives only the second line; four-wire mode drives all
  assign io_out = quad_ff ? out_shift_ff[7:4] : {2'b00, out_shift_ff[7], 1'b0};
  assign io_oe  = tx_en_ff ? (quad_ff ? 4'hf : 4'h2) : 4'h0;

  assign busy                   = busy_ff;
  assign write_enable_latch     = wen_ff;
  assign four_wire_command_mode = quad_ff;
  assign read_parameter_byte    = rparam_ff;
  assign serial_wrap_bits       = swrap_ff;
  // fixed count in serial mode; the host reprograms it after the mode switch
  assign fast_read_dummy_clocks = quad_ff ? {1'b0, rparam_ff[5:4], 1'b0} + `DUMMY_MIN : `SPI_FAST_DUMMY;
  assign wrap_length            = `WRAP_MIN << (quad_ff ? rparam_ff[1:0] : swrap_ff);

endmodule // flash_id_security_param_cmds

// ---- test/flash_cmd_monitor.sv ----
`timescale 1ns/1ps
`include "flash_cmd_consts.vh"
module flash_cmd_monitor #(
  parameter erase_time_us = 2
) (
  input wire       clk,
  input wire       rst,
  input wire       cs_n,
  input wire       sclk,
  input wire       serial_in,
  input wire [2:0] quad_in,
  input wire [3:0] io_out,
  input wire [3:0] io_oe,
  input wire       quad_enable_bit,
  input wire [2:0] security_lock_bits,
  input wire       busy,
  input wire       write_enable_latch,
  input wire       four_wire_command_mode,
  input wire [7:0] read_parameter_byte,
  input wire [1:0] serial_wrap_bits,
  input wire [3:0] fast_read_dummy_clocks,
  input wire [6:0] wrap_length
);
  localparam int busy_limit = erase_time_us * `CLK_MHZ;
  int        busy_cnt_ff;
  wire       four = four_wire_command_mode;
  wire [7:0] rp   = read_parameter_byte;
  wire [1:0] wcode = four ? rp[1:0] : serial_wrap_bits;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****************************************************************
  // erase length counter, cleared whenever busy drops
  // ****************************************************************
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      busy_cnt_ff <= 0;
    else
      busy_cnt_ff <= busy ? busy_cnt_ff + 1 : 0;
  end
  // ****************************************************************
  // assertions
  // ****************************************************************
  a_oe_legal_code: assert property (io_oe == 4'h0 || io_oe == 4'h2 || io_oe == 4'hf)
    else $error("output enable outside the allowed codes");
  a_quad_drive_mode: assert property (io_oe == 4'hf |-> four)
    else $error("four lines driven outside four-wire mode");
  a_serial_drive_mode: assert property (io_oe == 4'h2 |-> !four)
    else $error("single line driven in four-wire mode");
  a_dummy_map: assert property (four |-> fast_read_dummy_clocks ==
    (rp[5:4] == 2'h0 ? 4'h2 : rp[5:4] == 2'h1 ? 4'h4 : rp[5:4] == 2'h2 ? 4'h6 : 4'h8))
    else $error("dummy count does not follow its select code");
  a_wrap_map: assert property (wrap_length ==
    (wcode == 2'h0 ? 7'h08 : wcode == 2'h1 ? 7'h10 : wcode == 2'h2 ? 7'h20 : 7'h40))
    else $error("wrap length does not follow its select code");
  a_erase_len_bound: assert property (busy_cnt_ff <= busy_limit)
    else $error("erase held busy too long");
  a_erase_drops_latch: assert property ($fell(busy) |-> !write_enable_latch)
    else $error("write enable still set after erase");
  a_busy_after_cs: assert property ($rose(busy) |-> cs_n && $past(cs_n))
    else $error("erase started while select low");
  a_enter_needs_qe: assert property ($rose(four) |-> $past(quad_enable_bit))
    else $error("four-wire mode entered without quad enable");
  a_idle_release: assert property (cs_n [*8] |-> io_oe == 4'h0)
    else $error("lines still driven with select high");
  // a few main scenarios
  c_erase: cover property ($rose(busy));
  c_four: cover property ($rose(four));
  c_serial_out: cover property (io_oe == 4'h2);
  c_wrap64: cover property (wrap_length == 7'h40);
endmodule // flash_cmd_monitor

bind flash_id_security_param_cmds flash_cmd_monitor #(.erase_time_us(erase_time_us)) u_mon (
  .clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .serial_in(serial_in), .quad_in(quad_in),
  .io_out(io_out), .io_oe(io_oe), .quad_enable_bit(quad_enable_bit), .security_lock_bits(security_lock_bits),
  .busy(busy), .write_enable_latch(write_enable_latch), .four_wire_command_mode(four_wire_command_mode),
  .read_parameter_byte(read_parameter_byte), .serial_wrap_bits(serial_wrap_bits),
  .fast_read_dummy_clocks(fast_read_dummy_clocks), .wrap_length(wrap_length));

// ---- test/flash_host_model.sv ----
`timescale 1ns/1ps
module flash_host_model (
  input  wire       clk,
  input  wire [3:0] io_out,
  input  wire [3:0] io_oe,
  output reg        cs_n,
  output reg        sclk,
  output reg        serial_in,
  output reg  [2:0] quad_in
);
  reg  [63:0] rx;
  reg  [3:0]  last_io;
  reg         drove;
  // released lines read as the inverse of their last value, so stale data never looks valid
  wire [3:0]  io_seen = (io_oe & io_out) | (~io_oe & ~last_io);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    serial_in = 1'b0;
    quad_in = 3'h0;
    rx = 64'h0;
    last_io = 4'h0;
    drove = 1'b0;
  end
  // one frame of nc link clocks, 8 system clocks each; clock idles low between frames
  task xfer(input int nc, input q, input [63:0] tx);
    int i;
    begin
      rx = 64'h0;
      drove = 1'b0;
      @(negedge clk);
      cs_n = 1'b0;
      for (i = 0; i < nc; i++)
      begin
        if (q)
          {quad_in, serial_in} = (i < 16) ? tx[63 - 4 * i -: 4] : 4'h0;
        else
          serial_in = (i < 64) ? tx[63 - i] : 1'b0;
        repeat (4) @(negedge clk);
        sclk = 1'b1;
        repeat (3) @(negedge clk);
        rx = q ? {rx[59:0], io_seen} : {rx[62:0], io_seen[1]};
        drove = drove | (io_oe != 4'h0);
        last_io = io_seen;
        @(negedge clk);
        sclk = 1'b0;
      end
      repeat (4) @(negedge clk);
      cs_n = 1'b1;
      repeat (20) @(negedge clk);
    end
  endtask
endmodule // flash_host_model

// ---- test/flash_id_security_param_cmds_tb.sv ----
`timescale 1ns/1ps
`include "flash_cmd_consts.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module flash_id_security_param_cmds_tb;
  localparam       et = 10;
  localparam [7:0] mk = 8'h5c; // arbitrary value
  localparam [7:0] mt = 8'h3a; // arbitrary value
  localparam [7:0] cc = 8'h16; // arbitrary value
  reg        clk = 1'b0;
  reg        rst = 1'b1;
  reg        qe  = 1'b0;
  reg  [2:0] lk  = 3'h0;
  wire       cs_n, sclk, sdi, busy, wen, four;
  wire [2:0] qin;
  wire [3:0] io_out, io_oe, dmy;
  wire [7:0] rpb;
  wire [1:0] swb;
  wire [6:0] wl;
  int        errors = 0;
  int        check_count = 0;
  // 40 MHz system clock
  always #12.5 clk = ~clk;
  flash_id_security_param_cmds #(.manufacturer_id(mk), .memory_type(mt), .capacity_code(cc), .erase_time_us(et)) u_dut (
    .clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .serial_in(sdi), .quad_in(qin), .io_out(io_out),
    .io_oe(io_oe), .quad_enable_bit(qe), .security_lock_bits(lk), .busy(busy), .write_enable_latch(wen),
    .four_wire_command_mode(four), .read_parameter_byte(rpb), .serial_wrap_bits(swb),
    .fast_read_dummy_clocks(dmy), .wrap_length(wl));
  flash_host_model u_host (.clk(clk), .io_out(io_out), .io_oe(io_oe), .cs_n(cs_n), .sclk(sclk),
    .serial_in(sdi), .quad_in(qin));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task complete_run;
    $display("mismatches %0d of %0d checks", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task s8(input [7:0] op, input q);
    u_host.xfer(q ? 2 : 8, q, {op, 56'h0});
  endtask
  task done(input string n);
    $display("test %s finished", n);
  endtask
  // erase attempt that must leave the device idle
  task try_erase(input [23:0] a, input int nc, input [2:0] l, input w);
    lk = l;
    s8(w ? `OP_WRITE_ENABLE : `OP_WRITE_DISABLE, 1'b0);
    u_host.xfer(nc, 0, {`OP_SEC_ERASE, a, 32'h0});
    `CHK(busy, 1'b0)
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_defaults;
    `CHK(rpb, `RPARAM_RESET)
    `CHK(wl, 7'h08)
    `CHK(four, 1'b0)
    done("defaults");
  endtask
  task t_id;
    u_host.xfer(40, 0, {`OP_JEDEC_ID, 56'h0});
    `CHK(u_host.rx[31:0], {mk, mt, cc, mk})
    done("id");
  endtask
  task t_param;
    u_host.xfer(56, 0, {`OP_READ_PARAM_AREA, 24'h000002, 8'h00, 24'h0});
    `CHK(u_host.rx[15:0], {`SFDP_SIG2, `SFDP_SIG3})
    done("param");
  endtask
  task t_erase;
    int n;
    s8(`OP_WRITE_ENABLE, 1'b0);
    u_host.xfer(32, 0, {`OP_SEC_ERASE, 24'h001000, 32'h0});
    `CHK(busy, 1'b1)
    u_host.xfer(16, 0, {`OP_READ_STATUS, 56'h0});
    `CHK(u_host.rx[7:0], 8'h03)
    u_host.xfer(48, 0, {`OP_SEC_READ, 24'h001000, 32'h0});
    `CHK(u_host.drove, 1'b0)
    n = 0;
    while (busy !== 1'b0 && n < 1000)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(n < 1000, 1'b1)
    if (n >= 1000)
      complete_run;
    `CHK(wen, 1'b0)
    done("erase");
  endtask
  task t_prog;
    s8(`OP_WRITE_ENABLE, 1'b0);
    u_host.xfer(48, 0, {`OP_SEC_PROGRAM, 24'h0010ff, 16'ha53c, 16'h0});
    u_host.xfer(56, 0, {`OP_SEC_READ, 24'h0010ff, 32'h0});
    `CHK(u_host.rx[15:0], 16'ha53c)
    s8(`OP_WRITE_ENABLE, 1'b0);
    u_host.xfer(40, 0, {`OP_SEC_PROGRAM, 24'h0010ff, 8'h0f, 24'h0});
    u_host.xfer(48, 0, {`OP_SEC_READ, 24'h0010ff, 32'h0});
    `CHK(u_host.rx[7:0], 8'h05)
    done("program");
  endtask
  task t_refuse;
    try_erase(24'h001000, 32, 3'h1, 1'b1);
    try_erase(24'h004000, 32, 3'h0, 1'b1);
    try_erase(24'h001100, 32, 3'h0, 1'b1);
    try_erase(24'h012000, 32, 3'h0, 1'b1);
    try_erase(24'h002000, 33, 3'h0, 1'b1);
    try_erase(24'h002000, 32, 3'h0, 1'b0);
    lk = 3'h1;
    s8(`OP_WRITE_ENABLE, 1'b0);
    u_host.xfer(40, 0, {`OP_SEC_PROGRAM, 24'h001000, 8'h00, 24'h0});
    u_host.xfer(48, 0, {`OP_SEC_READ, 24'h001000, 32'h0});
    `CHK(u_host.rx[7:0], 8'h3c)
    lk = 3'h0;
    done("refuse");
  endtask
  task t_four;
    int k;
    s8(`OP_ENTER_FOUR_WIRE, 1'b0);
    `CHK(four, 1'b0)
    u_host.xfer(16, 0, {`OP_SET_READ_PARAMS, 8'h33, 48'h0});
    `CHK(rpb, 8'h00)
    u_host.xfer(40, 0, {`OP_SET_BURST_WRAP, 24'h0, 8'h20, 24'h0});
    `CHK(swb, 2'h2)
    qe = 1'b1;
    s8(`OP_ENTER_FOUR_WIRE, 1'b0);
    `CHK(four, 1'b1)
    `CHK(wl, 7'h20)
    `CHK(dmy, 4'h2)
    for (k = 0; k < 4; k++)
    begin
      u_host.xfer(4, 1, {`OP_SET_READ_PARAMS, 2'h0, k[1:0], 2'h0, k[1:0], 48'h0});
      `CHK(dmy, 4'(2 + 2 * k))
      `CHK(wl, 7'(8 << k))
    end
    u_host.xfer(24, 1, {`OP_SEC_READ, 24'h001000, 32'h0});
    `CHK(u_host.drove, 1'b0)
    s8(`OP_WRITE_ENABLE, 1'b1);
    s8(`OP_RESET_ENABLE, 1'b1);
    s8(`OP_RESET_DEVICE, 1'b1);
    `CHK(four, 1'b0)
    `CHK(rpb, 8'h00)
    `CHK(wen, 1'b0)
    `CHK(wl, 7'h08)
    done("four_wire");
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    t_defaults;
    t_id;
    t_param;
    t_erase;
    t_prog;
    t_refuse;
    t_four;
    complete_run;
  end
endmodule // flash_id_security_param_cmds_tb
